// [hdl/ddac_pkg.sv]
// Constants shared by the dual DAC serial register map and its frame receiver.
// Assumes a 40 MHz system clock and a host that shifts 24-bit frames.
package ddac_pkg;
   // Frame layout, most significant bit first on the wire.
   localparam int FRAME_BITS = 24;
   localparam int DATA_W     = 16;
   localparam int RW_BIT     = 23;
   localparam int RSV_BIT    = 22;
   localparam int REG_MSB    = 21;
   localparam int REG_LSB    = 19;
   localparam int ADR_MSB    = 18;
   localparam int ADR_LSB    = 16;

   // Register select field codes.
   localparam logic [2:0] REG_VALUE = 3'h0;
   localparam logic [2:0] REG_SPAN  = 3'h1;
   localparam logic [2:0] REG_POWER = 3'h2;
   localparam logic [2:0] REG_CTRL  = 3'h3;

   // Channel address field codes.
   localparam logic [2:0] ADR_CHAN_A = 3'h0;
   localparam logic [2:0] ADR_CHAN_B = 3'h2;
   localparam logic [2:0] ADR_BOTH   = 3'h4;

   // Control function selectors carried in the channel address field.
   localparam logic [2:0] FN_NOP   = 3'h0;
   localparam logic [2:0] FN_CFG   = 3'h1;
   localparam logic [2:0] FN_CLEAR = 3'h4;
   localparam logic [2:0] FN_LOAD  = 3'h5;

   // Configuration bit positions and reset value (clamp enabled only).
   localparam int CFG_TSD_EN  = 3;
   localparam int CFG_CLAMP   = 2;
   localparam int CFG_CLR_SEL = 1;
   localparam int CFG_SDO_DIS = 0;
   localparam logic [3:0] CFG_RESET = 4'h4;

   // Power control word bit positions.
   localparam int PWR_PU_A  = 0;
   localparam int PWR_PU_B  = 2;
   localparam int PWR_TSD   = 5;
   localparam int PWR_OC_A  = 7;
   localparam int PWR_OC_B  = 9;
   localparam int PWR_ZERO  = 10;

   // Span codes; codes from SPAN_PM5 upward are bipolar.
   localparam logic [2:0] SPAN_P5     = 3'h0;
   localparam logic [2:0] SPAN_P10    = 3'h1;
   localparam logic [2:0] SPAN_P10_8  = 3'h2;
   localparam logic [2:0] SPAN_PM5    = 3'h3;
   localparam logic [2:0] SPAN_PM10   = 3'h4;
   localparam logic [2:0] SPAN_PM10_8 = 3'h5;
   localparam logic [2:0] SPAN_RESET  = 3'h0;

   // Codes for zero and midscale in straight or offset binary.
   localparam logic [15:0] CODE_ZERO  = 16'h0000;
   localparam logic [15:0] CODE_MID   = 16'h8000;
   localparam logic [15:0] VALUE_RESET = 16'h0000;

   // Host power-up wait, kept for benches that check host pacing.
   localparam int CLK_PERIOD_PS  = 25000;
   localparam int PWR_UP_TIME_NS = 10000;
   localparam int PWR_UP_CYCLES  = (PWR_UP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic {RX_IDLE, RX_SHIFT} ddac_rx_state_t;
endpackage

// [hdl/ddac_link_if.sv]
// Carries received frames and readback words between receiver and register map.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface ddac_link_if;
   logic        frame_valid;
   logic [23:0] frame_word;
   logic        frame_active;
   logic        serial_data_out;
   logic        tx_load;
   logic [23:0] tx_word;

   modport rx   (output frame_valid, frame_word, frame_active, serial_data_out, input tx_load, tx_word);
   modport core (input frame_valid, frame_word, frame_active, serial_data_out, output tx_load, tx_word);
endinterface

// [hdl/ddac_serial_rx.sv]
// Serial frame receiver: synchronises the link pins, shifts frames in and
// readback words out. Assumes the link clock is much slower than clk.
`timescale 1ns/1ps
module ddac_serial_rx #(
   parameter int FRAME_BITS = ddac_pkg::FRAME_BITS
) (
   input  wire logic  clk,
   input  wire logic  rst_n,
   input  wire logic  sclk,
   input  wire logic  sync_n,
   input  wire logic  serial_data_in,
   ddac_link_if.rx    lnk
);
   logic [2:0]            sclk_q;
   logic [1:0]            sync_q;
   logic [1:0]            serial_data_in_q;
   logic [FRAME_BITS-1:0] rx_q;
   logic [FRAME_BITS-1:0] tx_q;
   logic [5:0]            cnt_q;
   logic                  valid_q;
   ddac_pkg::ddac_rx_state_t state_q;

   // Edges are taken between the second and third stages, never the first.
   wire sclk_fall = sclk_q[2] & ~sclk_q[1];
   wire sclk_rise = ~sclk_q[2] & sclk_q[1];
   wire in_frame  = (state_q == ddac_pkg::RX_SHIFT);
   wire frame_end = in_frame & sync_q[1];

   // Pin synchronisers.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sclk_q <= 3'h7;
         sync_q <= 2'h3;
         serial_data_in_q <= 2'h0;
      end else begin
         sclk_q <= {sclk_q[1:0], sclk};
         sync_q <= {sync_q[0], sync_n};
         serial_data_in_q <= {serial_data_in_q[0], serial_data_in};
      end
   end

   // Frame state: data is taken on falling link-clock edges, readback moves on rising ones.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= ddac_pkg::RX_IDLE;
         cnt_q   <= 6'h00;
         rx_q    <= '0;
         tx_q    <= '0;
         valid_q <= 1'b0;
      end else begin
         valid_q <= frame_end && (cnt_q == 6'(FRAME_BITS)); // see RQ1
         case (state_q)
            ddac_pkg::RX_IDLE: begin
               if (lnk.tx_load) begin
                  tx_q <= lnk.tx_word;
               end
               if (!sync_q[1]) begin
                  state_q <= ddac_pkg::RX_SHIFT;
                  cnt_q   <= 6'h00;
               end
            end
            ddac_pkg::RX_SHIFT: begin
               if (sync_q[1]) begin
                  state_q <= ddac_pkg::RX_IDLE;
               end else if (sclk_fall) begin
                  rx_q <= {rx_q[FRAME_BITS-2:0], serial_data_in_q[1]}; // see RQ1
                  if (cnt_q != 6'h3F) begin
                     cnt_q <= cnt_q + 6'h01;
                  end
               end else if (sclk_rise && cnt_q != 6'h00) begin
                  tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
               end
            end
            default: state_q <= ddac_pkg::RX_IDLE;
         endcase
      end
   end

   assign lnk.frame_valid  = valid_q;
   assign lnk.frame_word   = rx_q;
   assign lnk.frame_active = in_frame;
   assign lnk.serial_data_out          = tx_q[FRAME_BITS-1];

   // A frame of the wrong length must never be taken.
   a_frame_length: assert property (@(posedge clk) disable iff (!rst_n)
      frame_end && cnt_q != 6'(FRAME_BITS) |=> !valid_q) else $error("short frame accepted"); // see RQ1
   c_frame_taken: cover property (@(posedge clk) disable iff (!rst_n) valid_q);
endmodule

// [hdl/ddac_regmap.sv]
// Register map and control logic of a dual voltage-output DAC behind a
// 24-bit serial port. Assumes fault and pin inputs are asynchronous to CLK.
//
// How it works
// (RQ1) Frame: 24 bits, MSB first, fixed fields.
// (RQ2) Address 000 A, 010 B, 100 both.
// (RQ3) Select 000 writes channel conversion values.
// (RQ4) Value left-aligned, low bits dropped by resolution.
// (RQ5) Select 001 stores span code bits 2..0.
// (RQ6) Span codes map to six output ranges.
// (RQ7) Select 011: address field picks function.
// (RQ8) Function 000 changes nothing.
// (RQ9) Function 100 loads clear code, updates outputs.
// (RQ10) Function 101 transfers values to outputs.
// (RQ11) Function 001 writes four configuration bits.
// (RQ12) Serial output disable bit, default enabled.
// (RQ13) Clear code by select bit and polarity.
// (RQ14) Clamp on: no overcurrent power-down.
// (RQ15) Thermal shutdown only when enabled, default off.
// (RQ16) Select 010, address 000 writes power word.
// (RQ17) Power word bits 0,2,5,7,9.
// (RQ18) Power-up bits start cleared, control channels.
// (RQ19) Host waits 10 us before loading.
// (RQ20) Clamp off: overcurrent clears power-up bit.
// (RQ21) Overtemperature powers both down, sets alert.
// (RQ22) Overcurrent sets channel overcurrent flag.
// (RQ23) Clamp mode: flag clears when fault gone.
// (RQ24) Unused bits ignored, read back zero.
`timescale 1ns/1ps
module ddac_regmap #(
   parameter int RES_BITS = 16
) (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        SCLK,
   input  wire logic        SYNC_N,
   input  wire logic        SERIAL_DATA_IN,
   input  wire logic        LOAD_OUTPUTS_PIN_N,
   input  wire logic        ASYNC_CLEAR_PIN_N,
   input  wire logic        OVERCURRENT_A,
   input  wire logic        OVERCURRENT_B,
   input  wire logic        OVERTEMP,
   output logic             SERIAL_DATA_OUT,
   output logic             SERIAL_DATA_OUT_OE_N,
   output logic [15:0]      OUT_CODE_A,
   output logic [15:0]      OUT_CODE_B,
   output logic [2:0]       SPAN_A,
   output logic [2:0]       SPAN_B,
   output logic             CHAN_A_POWER_ON,
   output logic             CHAN_B_POWER_ON,
   output logic             CLAMP_ENABLE,
   output logic             THERMAL_SHUTDOWN_ENABLE
);
   ddac_link_if lnk ();

   ddac_serial_rx #(
      .FRAME_BITS (ddac_pkg::FRAME_BITS)
   ) u_rx (
      .clk    (CLK),
      .rst_n  (RST_N),
      .sclk   (SCLK),
      .sync_n (SYNC_N),
      .serial_data_in   (SERIAL_DATA_IN),
      .lnk    (lnk.rx)
   );

   // Keeps the converter's resolution left-aligned in the 16-bit field.
   function automatic logic [15:0] align_value(input logic [15:0] d);
      logic [15:0] mask;
      mask = 16'hFFFF << (16 - RES_BITS);
      return d & mask;
   endfunction

   // Codes from SPAN_PM5 up are bipolar; offset binary is assumed there.
   function automatic logic [15:0] clear_code(input logic [2:0] span, input logic sel);
      logic bipolar;
      bipolar = (span >= ddac_pkg::SPAN_PM5);
      if (!sel) begin
         return bipolar ? ddac_pkg::CODE_MID : ddac_pkg::CODE_ZERO;
      end
      return bipolar ? ddac_pkg::CODE_ZERO : ddac_pkg::CODE_MID;
   endfunction

   // Asynchronous pins: two stages, then a third only for edge detection.
   logic [4:0] pin_s1_q;
   logic [4:0] pin_s2_q;
   logic [1:0] pin_s3_q;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         pin_s1_q <= 5'h03;
         pin_s2_q <= 5'h03;
         pin_s3_q <= 2'h3;
      end else begin
         pin_s1_q <= {OVERTEMP, OVERCURRENT_B, OVERCURRENT_A,
                      ASYNC_CLEAR_PIN_N, LOAD_OUTPUTS_PIN_N};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q[1:0];
      end
   end

   wire       load_outputs_pin_fall  = pin_s3_q[0] & ~pin_s2_q[0];
   wire       clr_fall   = pin_s3_q[1] & ~pin_s2_q[1];
   wire [1:0] oc_in      = pin_s2_q[3:2];
   wire       overtemp_s = pin_s2_q[4];

   // Registers of the map.
   logic [15:0] val_q [2];
   logic [15:0] out_q [2];
   logic [2:0]  span_q [2];
   logic [3:0]  cfg_q;
   logic [1:0]  pu_q;
   logic [1:0]  oc_q;
   logic        tsd_flag_q;
   logic [15:0] val_d [2];
   logic [15:0] out_d [2];
   logic [2:0]  span_d [2];
   logic [1:0]  pu_d;
   logic [1:0]  oc_d;
   logic        tsd_flag_d;

   // Frame field decode.
   wire [23:0] fw       = lnk.frame_word;
   wire        wr       = lnk.frame_valid & ~fw[ddac_pkg::RW_BIT];
   wire        rd       = lnk.frame_valid & fw[ddac_pkg::RW_BIT];
   wire [2:0]  reg_sel  = fw[ddac_pkg::REG_MSB:ddac_pkg::REG_LSB];
   wire [2:0]  chan_adr = fw[ddac_pkg::ADR_MSB:ddac_pkg::ADR_LSB];
   wire [15:0] data     = fw[15:0];

   // Channel decode: patterns outside the three listed select nothing.
   wire [1:0] chan_sel = {chan_adr == ddac_pkg::ADR_CHAN_B || chan_adr == ddac_pkg::ADR_BOTH,
                          chan_adr == ddac_pkg::ADR_CHAN_A || chan_adr == ddac_pkg::ADR_BOTH}; // see RQ2

   wire wr_val  = wr && reg_sel == ddac_pkg::REG_VALUE;                          // see RQ3
   wire wr_span = wr && reg_sel == ddac_pkg::REG_SPAN;                           // see RQ5
   wire wr_pwr  = wr && reg_sel == ddac_pkg::REG_POWER && chan_adr == 3'h0;      // see RQ16
   wire wr_ctl  = wr && reg_sel == ddac_pkg::REG_CTRL;                           // see RQ7
   wire fn_nop  = wr_ctl && chan_adr == ddac_pkg::FN_NOP;                        // see RQ8
   wire fn_cfg  = wr_ctl && chan_adr == ddac_pkg::FN_CFG;                        // see RQ11
   wire fn_clr  = (wr_ctl && chan_adr == ddac_pkg::FN_CLEAR) || clr_fall;        // see RQ9
   wire fn_load = (wr_ctl && chan_adr == ddac_pkg::FN_LOAD) || load_outputs_pin_fall;        // see RQ10

   wire       clamp_on  = cfg_q[ddac_pkg::CFG_CLAMP];
   wire       tsd_trip  = overtemp_s & cfg_q[ddac_pkg::CFG_TSD_EN];              // see RQ15
   wire [1:0] pu_wdata  = {data[ddac_pkg::PWR_PU_B], data[ddac_pkg::PWR_PU_A]};  // see RQ17
   wire [1:0] oc_trip   = oc_in & {2{~clamp_on}};                                // see RQ14

   // Next state per channel. Hardware power-down beats a host power-up write,
   // and a fault that is still present beats any clear of its flag.
   always_comb begin
      tsd_flag_d = tsd_trip ? 1'b1 : (wr_pwr ? 1'b0 : tsd_flag_q);                 // see RQ21
      for (int i = 0; i < 2; i++) begin
         val_d[i]  = val_q[i];
         out_d[i]  = out_q[i];
         span_d[i] = span_q[i];
         if (wr_span && chan_sel[i]) begin
            span_d[i] = data[2:0];                                                // see RQ5
         end
         if (fn_clr) begin
            val_d[i] = clear_code(span_q[i], cfg_q[ddac_pkg::CFG_CLR_SEL]);       // see RQ13
            out_d[i] = val_d[i];                                                  // see RQ9
         end else begin
            if (wr_val && chan_sel[i]) begin
               val_d[i] = align_value(data);                                      // see RQ4
            end
            if (fn_load) begin
               out_d[i] = val_q[i];                                               // see RQ10
            end
         end
         if (tsd_trip || oc_trip[i]) begin
            pu_d[i] = 1'b0;                                                       // see RQ20
         end else if (wr_pwr) begin
            pu_d[i] = pu_wdata[i];                                                // see RQ18
         end else begin
            pu_d[i] = pu_q[i];
         end
         if (oc_in[i]) begin
            oc_d[i] = 1'b1;                                                       // see RQ22
         end else if (clamp_on || (wr_pwr && pu_wdata[i])) begin
            oc_d[i] = 1'b0;                                                       // see RQ23
         end else begin
            oc_d[i] = oc_q[i];
         end
      end
   end

   // Register update; power-up bits and thermal enable start cleared.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         for (int i = 0; i < 2; i++) begin
            val_q[i]  <= ddac_pkg::VALUE_RESET;
            out_q[i]  <= ddac_pkg::VALUE_RESET;
            span_q[i] <= ddac_pkg::SPAN_RESET;
         end
         cfg_q      <= ddac_pkg::CFG_RESET;                                       // see RQ15
         pu_q       <= 2'h0;                                                      // see RQ18
         oc_q       <= 2'h0;
         tsd_flag_q <= 1'b0;
      end else begin
         val_q      <= val_d;
         out_q      <= out_d;
         span_q     <= span_d;
         cfg_q      <= fn_cfg ? data[3:0] : cfg_q;                                // see RQ11
         pu_q       <= pu_d;
         oc_q       <= oc_d;
         tsd_flag_q <= tsd_flag_d;
      end
   end

   // Readback word; every position not holding a field reads as zero.
   wire [15:0] pwr_word = {5'h00, 1'b0, oc_q[1], 1'b0, oc_q[0], 1'b0, tsd_flag_q,
                           2'h0, pu_q[1], 1'b0, pu_q[0]};                         // see RQ24
   wire [15:0] rd_val   = (chan_adr == ddac_pkg::ADR_CHAN_B) ? val_q[1] : val_q[0];
   wire [15:0] rd_data  = (reg_sel == ddac_pkg::REG_VALUE) ? rd_val :
                          (reg_sel == ddac_pkg::REG_SPAN)  ?
                             {13'h0000, (chan_adr == ddac_pkg::ADR_CHAN_B) ? span_q[1] : span_q[0]} :
                          (reg_sel == ddac_pkg::REG_POWER) ? pwr_word :
                          (reg_sel == ddac_pkg::REG_CTRL)  ? {12'h000, cfg_q} : 16'h0000; // see RQ24

   assign lnk.tx_load = rd;
   assign lnk.tx_word = {fw[23:16], rd_data};

   // Outputs are all registered so pins never see decode glitches.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         SERIAL_DATA_OUT         <= 1'b0;
         SERIAL_DATA_OUT_OE_N    <= 1'b1;
         OUT_CODE_A              <= ddac_pkg::VALUE_RESET;
         OUT_CODE_B              <= ddac_pkg::VALUE_RESET;
         SPAN_A                  <= ddac_pkg::SPAN_RESET;
         SPAN_B                  <= ddac_pkg::SPAN_RESET;
         CHAN_A_POWER_ON         <= 1'b0;
         CHAN_B_POWER_ON         <= 1'b0;
         CLAMP_ENABLE            <= 1'b1;
         THERMAL_SHUTDOWN_ENABLE <= 1'b0;
      end else begin
         SERIAL_DATA_OUT         <= lnk.serial_data_out;
         SERIAL_DATA_OUT_OE_N    <= cfg_q[ddac_pkg::CFG_SDO_DIS] | ~lnk.frame_active; // see RQ12
         OUT_CODE_A              <= out_q[0];
         OUT_CODE_B              <= out_q[1];
         SPAN_A                  <= span_q[0];                                    // see RQ6
         SPAN_B                  <= span_q[1];
         CHAN_A_POWER_ON         <= pu_q[0];
         CHAN_B_POWER_ON         <= pu_q[1];
         CLAMP_ENABLE            <= cfg_q[ddac_pkg::CFG_CLAMP];
         THERMAL_SHUTDOWN_ENABLE <= cfg_q[ddac_pkg::CFG_TSD_EN];
      end
   end

   // Checks on the map.
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);

   a_span_store: assert property (wr_span && chan_sel[0] |=> span_q[0] == $past(data[2:0]))
      else $error("span code not stored"); // see RQ5
   a_value_align: assert property (wr_val && chan_sel[1] |=>
      val_q[1] == align_value($past(data)))
      else $error("value not aligned"); // see RQ4
   a_clear_code: assert property (fn_clr |=> out_q[0] == val_q[0] &&
      val_q[0] == clear_code(span_q[0], cfg_q[ddac_pkg::CFG_CLR_SEL]))
      else $error("clear code wrong"); // see RQ9
   a_load_outputs: assert property (fn_load && !fn_clr |=> out_q[1] == $past(val_q[1]) ##1
      OUT_CODE_B == $past(out_q[1]))
      else $error("load did not reach output"); // see RQ10
   a_nop_quiet: assert property (fn_nop && !clr_fall && !load_outputs_pin_fall |=>
      $stable(cfg_q) && $stable(out_q[0]) && $stable(val_q[0]))
      else $error("no-op changed state"); // see RQ8
   a_oc_shutdown: assert property (oc_in[0] && !clamp_on |=> !pu_q[0] && oc_q[0] ##2
      !CHAN_A_POWER_ON)
      else $error("overcurrent did not power down"); // see RQ20
   a_thermal_trip: assert property (tsd_trip |=> pu_q == 2'h0 && tsd_flag_q)
      else $error("thermal trip missed"); // see RQ21
   a_clamp_clears: assert property (!oc_in[0] && clamp_on |=> !oc_q[0])
      else $error("overcurrent flag stuck in clamp mode"); // see RQ23
   a_power_write: assert property (wr_pwr && !tsd_trip && oc_trip == 2'h0 |=>
      pu_q == $past(pu_wdata))
      else $error("power word not stored"); // see RQ16
   a_serial_out_disable: assert property (cfg_q[ddac_pkg::CFG_SDO_DIS] |=> SERIAL_DATA_OUT_OE_N)
      else $error("serial output driven while disabled"); // see RQ12

   c_load_both: cover property (wr_val && chan_adr == ddac_pkg::ADR_BOTH ##[1:1000] fn_load);
   c_oc_power_down: cover property (oc_trip[1] ##1 !pu_q[1]);
   c_readback: cover property (rd && reg_sel == ddac_pkg::REG_POWER);
endmodule

// [tb/ddac_host_model.sv]
// Host side of the serial link: frames 24-bit words onto the link pins.
// Assumes the system clock runs at 40 MHz, so 4 cycles make a link half period.
`timescale 1ns/1ps
module ddac_host_model (
   input  wire logic clk,
   input  wire logic oe_n,
   input  wire logic serial_data_out,
   output logic      sclk,
   output logic      sync_n,
   output logic      serial_data_in
);
   logic        oe_seen;
   logic [23:0] got;

   // The link clock idles high and stands still between frames.
   initial begin
      sclk = 1'b1;
      sync_n = 1'b1;
      serial_data_in = 1'b0;
      oe_seen = 1'b0;
   end

   // Holds each link level for 4 system clocks, changing just after an edge.
   task automatic half();
      repeat (4) @(posedge clk);
      #2;
   endtask

   // Sends the top nbits of w, data set while the link clock is high.
   task automatic send(input logic [23:0] w, input int nbits);
      oe_seen = 1'b0;
      got = '0;
      @(posedge clk);
      #2;
      sync_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         serial_data_in = w[23-i];
         half();
         sclk = 1'b0;
         if (oe_n === 1'b0) oe_seen = 1'b1;
         got = {got[22:0], serial_data_out}; // Readback bit of the previous read frame.
         half();
         sclk = 1'b1;
      end
      half();
      sync_n = 1'b1;
      serial_data_in = ~serial_data_in; // Released data line must not keep showing the last bit.
      repeat (12) @(posedge clk);
   endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the dual DAC register map with an integer model.
// Assumes the host model drives the link and the design runs with 14-bit data.
`timescale 1ns/1ps
module testbench;
   localparam int RES = 14;
   logic        clk, rst_n, load_n, clr_n, oc_a, oc_b, otemp;
   logic        sclk, sync_n, serial_data_in, serial_data_out, oe_n, pu_a, pu_b, clamp, tsd_en;
   logic [15:0] code_a, code_b;
   logic [2:0]  span_a, span_b;
   int          errors, total_checks, m_cfg;
   int          m_val[2], m_out[2], m_span[2], m_pu[2];

   ddac_host_model host (.clk(clk), .oe_n(oe_n), .serial_data_out(serial_data_out), .sclk(sclk), .sync_n(sync_n),
      .serial_data_in(serial_data_in));
   ddac_regmap #(.RES_BITS(RES)) i_dut (.CLK(clk), .RST_N(rst_n), .SCLK(sclk),
      .SYNC_N(sync_n), .SERIAL_DATA_IN(serial_data_in), .LOAD_OUTPUTS_PIN_N(load_n),
      .ASYNC_CLEAR_PIN_N(clr_n), .OVERCURRENT_A(oc_a), .OVERCURRENT_B(oc_b),
      .OVERTEMP(otemp), .SERIAL_DATA_OUT(serial_data_out), .SERIAL_DATA_OUT_OE_N(oe_n),
      .OUT_CODE_A(code_a), .OUT_CODE_B(code_b), .SPAN_A(span_a), .SPAN_B(span_b),
      .CHAN_A_POWER_ON(pu_a), .CHAN_B_POWER_ON(pu_b), .CLAMP_ENABLE(clamp),
      .THERMAL_SHUTDOWN_ENABLE(tsd_en));

   // Clock of 25 ns period.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk_code(input string nm, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_flag(input string nm, input logic [2:0] e, input logic [2:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Clear code: zero or midscale, swapped by polarity since bipolar is offset binary.
   task automatic clear_model();
      for (int c = 0; c < 2; c++) begin
         m_val[c] = (((m_cfg >> 1) & 1) ^ int'(m_span[c] >= 3)) ? 16'h8000 : 16'h0000;
      end
      m_out = m_val;
   endtask

   // Sends one write frame and applies it to the model.
   task automatic wr(input logic [2:0] rs, input logic [2:0] ad, input logic [15:0] d);
      logic oe_exp;
      oe_exp = ~m_cfg[0];
      host.send({2'h0, rs, ad, d}, 24);
      chk_flag("oe_seen", oe_exp, host.oe_seen);
      for (int c = 0; c < 2; c++) begin
         if (ad == 3'h4 || ad == (c ? 3'h2 : 3'h0)) begin
            if (rs == ddac_pkg::REG_VALUE) m_val[c] = (int'(d) >> (16 - RES)) << (16 - RES);
            if (rs == ddac_pkg::REG_SPAN) m_span[c] = d[2:0];
         end
      end
      if (rs == ddac_pkg::REG_POWER && ad == 3'h0) begin
         m_pu[0] = d[0];
         m_pu[1] = d[2];
      end
      if (rs == ddac_pkg::REG_CTRL && ad == ddac_pkg::FN_CFG) m_cfg = d[3:0];
      if (rs == ddac_pkg::REG_CTRL && ad == ddac_pkg::FN_CLEAR) clear_model();
      if (rs == ddac_pkg::REG_CTRL && ad == ddac_pkg::FN_LOAD) m_out = m_val;
   endtask

   task automatic check_all();
      chk_code("code_a", m_out[0], code_a);
      chk_code("code_b", m_out[1], code_b);
      chk_flag("span_a", m_span[0], span_a);
      chk_flag("span_b", m_span[1], span_b);
      chk_flag("pu_a", m_pu[0], pu_a);
      chk_flag("pu_b", m_pu[1], pu_b);
      chk_flag("clamp", m_cfg[2], clamp);
      chk_flag("tsd_en", m_cfg[3], tsd_en);
   endtask

   // Holds a pin at lvl for 8 cycles, then releases it and lets the effect land.
   task automatic pulse(ref logic p, input logic lvl);
      @(posedge clk);
      #2;
      p = lvl;
      repeat (8) @(posedge clk);
      #2;
      p = ~lvl;
      repeat (8) @(posedge clk);
   endtask

   // Main sequence; values come from a fixed seed so every run repeats.
   initial begin
      void'($urandom(27));
      {rst_n, oc_a, oc_b, otemp, errors, total_checks} = '0;
      {load_n, clr_n} = 2'b11;
      m_val = '{0, 0};
      m_out = '{0, 0};
      m_span = '{0, 0};
      m_pu = '{0, 0};
      m_cfg = ddac_pkg::CFG_RESET;
      repeat (8) @(posedge clk);
      #2 rst_n = 1'b1;
      repeat (4) @(posedge clk);
      check_all();
      chk_flag("oe_idle", 3'h1, oe_n);
      // Value writes to addresses 0, 2, 4, 6 and 1, the last two unused, then a load.
      for (int a = 0; a < 8; a += 2) begin
         wr(ddac_pkg::REG_VALUE, 3'(a), 16'($urandom));
         check_all();
      end
      wr(ddac_pkg::REG_VALUE, 3'h1, 16'($urandom));
      wr(ddac_pkg::REG_CTRL, ddac_pkg::FN_LOAD, 16'($urandom));
      check_all();
      // Every span code, addresses rotating, junk in the ignored bits.
      for (int s = 0; s < 6; s++) begin
         wr(ddac_pkg::REG_SPAN, 3'(2 * (s % 3)), {13'($urandom), 3'(s)});
         check_all();
      end
      // Clear by frame and by pin over both select values and polarities.
      for (int sel = 0; sel < 2; sel++) begin
         wr(ddac_pkg::REG_SPAN, 3'h0, 16'h0001);
         wr(ddac_pkg::REG_CTRL, ddac_pkg::FN_CFG, {12'($urandom), 2'b01, 1'(sel), 1'b0});
         wr(ddac_pkg::REG_VALUE, 3'h4, 16'($urandom));
         wr(ddac_pkg::REG_CTRL, ddac_pkg::FN_CLEAR, 16'($urandom));
         check_all();
         wr(ddac_pkg::REG_VALUE, 3'h4, 16'($urandom));
         pulse(load_n, 1'b0);
         m_out = m_val;
         check_all();
         pulse(clr_n, 1'b0);
         clear_model();
         check_all();
      end
      // No-op, short frame and serial output disabled change nothing else.
      wr(ddac_pkg::REG_CTRL, ddac_pkg::FN_NOP, 16'($urandom));
      host.send({8'h00, 16'h1234}, 23);
      check_all();
      wr(ddac_pkg::REG_CTRL, ddac_pkg::FN_CFG, 16'h0005);
      wr(ddac_pkg::REG_CTRL, ddac_pkg::FN_NOP, 16'h0000);
      // Power words with junk in the ignored bits; a misaddressed one is dropped.
      wr(ddac_pkg::REG_POWER, 3'h0, (16'($urandom) & 16'hFBFA) | 16'h0005);
      wr(ddac_pkg::REG_POWER, 3'h2, 16'h0000);
      check_all();
      repeat (ddac_pkg::PWR_UP_CYCLES) @(posedge clk);
      // Overcurrent under clamp, then with clamp off.
      wr(ddac_pkg::REG_CTRL, ddac_pkg::FN_CFG, 16'h0004);
      pulse(oc_a, 1'b1);
      check_all();
      wr(ddac_pkg::REG_CTRL, ddac_pkg::FN_CFG, 16'h0000);
      pulse(oc_b, 1'b1);
      pulse(oc_a, 1'b1);
      m_pu = '{0, 0};
      check_all();
      // Overtemperature ignored while disabled, powers both down when enabled.
      wr(ddac_pkg::REG_POWER, 3'h0, 16'h0005);
      // Read the power word back; it comes out during the following no-op frame.
      host.send({1'b1, 1'b0, ddac_pkg::REG_POWER, 3'h0, 16'h0000}, 24);
      wr(ddac_pkg::REG_CTRL, ddac_pkg::FN_NOP, 16'h0000);
      chk_code("rb_head", 16'h0090, 16'(host.got[23:16]));
      chk_code("rb_power", 16'(m_pu[0] + 4 * m_pu[1]), host.got[15:0]);
      pulse(otemp, 1'b1);
      check_all();
      wr(ddac_pkg::REG_CTRL, ddac_pkg::FN_CFG, 16'h0008);
      pulse(otemp, 1'b1);
      m_pu = '{0, 0};
      check_all();
      final_report();
   end

   // Watchdog sized well above the roughly 190 us the sequence needs.
   initial begin
      #2000000;
      errors++;
      final_report();
   end
endmodule
